// *** core/board_system_bus_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "board_bus_defines.svh"
module board_system_bus_interface (
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor core side
  input wire board_bus_pkg::cpu_req_s cpu_req,
  input wire logic irq_n,
  input wire logic nmi_n,
  output logic cpu_step,
  output logic cpu_reset_n,
  output logic [`DATA_W-1:0] cpu_rdata,
  // backplane
  input wire logic run_stop,
  output logic bus_released,
  output logic [`ADDR_W-1:0] address_out,
  output logic address_oe,
  input wire logic [`DATA_W-1:0] data_n_in,
  output logic [`DATA_W-1:0] data_n_out,
  output logic [`DATA_W-1:0] data_n_oe,
  output logic read_write,
  output logic memory_address_valid,
  input wire logic user_address_valid_qualifier_in,
  output logic user_address_valid_qualifier_out,
  output logic user_address_valid_qualifier_oe,
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe,
  input wire logic refresh_request_n,
  output logic refresh_grant,
  output logic phase_one_clock,
  output logic phase_two_clock,
  output logic ungated_memory_clock,
  // first parallel adapter, port A
  input wire logic [`DATA_W-1:0] first_adapter_port_a_line_in,
  output logic [`DATA_W-1:0] first_adapter_port_a_line_out,
  output logic [`DATA_W-1:0] first_adapter_port_a_line_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  board_bus_pkg::run_state_e state_q;
  board_bus_pkg::run_state_e state_d;
  logic [`PHASE_CNT_W-1:0] phase_cnt_q;
  logic phase_two_half_q;
  logic phase_one_lead;
  logic cycle_en;
  logic nmi_n_q;
  logic nmi_pending_q;
  logic bus_active;
  logic data_drive;
  logic [`RESET_CNT_W-1:0] por_cnt_q;
  logic [`DATA_W-1:0] adapter_ctrl_q;
  logic [`DATA_W-1:0] direction_q;
  logic [`DATA_W-1:0] port_a_out_q;
  logic [`DATA_W-1:0] port_a_sample;
  logic [`DATA_W-1:0] board_cfg_q;
  logic [`AXI_ADDR_W-1:0] awaddr_q;
  logic [`DATA_W-1:0] wdata_q;
  logic wstrb0_q;
  logic aw_have_q;
  logic w_have_q;
  logic do_write;
  logic [`DATA_W-1:0] port_a_view;
  logic [`DATA_W-1:0] status_view;

  ////////////////////////////////////////////////////////////////////////////
  // two-phase clock generator

  // one half of the processor clock is PHASE_HALF_CYCLES fast clocks long
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_cnt_q <= '0;
      phase_two_half_q <= 1'b0;
    end else if (phase_cnt_q == `PHASE_CNT_W'(`PHASE_HALF_CYCLES - 1)) begin
      phase_cnt_q <= '0;
      phase_two_half_q <= !phase_two_half_q;
    end else begin
      phase_cnt_q <= phase_cnt_q + 1'b1;
    end
  end

  assign phase_one_lead = (phase_cnt_q == `PHASE_CNT_W'(`PHASE_HALF_CYCLES - 1))
    && phase_two_half_q;
  // a stopped processor clock means no machine cycle either
  assign cycle_en = phase_one_lead && !refresh_grant;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_grant <= 1'b0;
    end else begin
      refresh_grant <= !refresh_request_n;
    end
  end

  // phase outputs follow the half counter one clock late, gated by refresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_one_clock <= 1'b0;
      phase_two_clock <= 1'b0;
      ungated_memory_clock <= 1'b0;
    end else begin
      phase_one_clock <= !phase_two_half_q && !refresh_grant;
      phase_two_clock <= phase_two_half_q && !refresh_grant;
      ungated_memory_clock <= phase_two_half_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset line

  // the line is open drain: we only ever pull it low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_q <= '0;
    end else if (por_cnt_q != `RESET_CNT_W'(`RESET_CYCLES)) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_line_out <= 1'b0;
      reset_line_oe <= 1'b1;
    end else begin
      reset_line_out <= 1'b0;
      reset_line_oe <= (por_cnt_q != `RESET_CNT_W'(`RESET_CYCLES))
        || board_cfg_q[`CFG_SOFT_RESET_BIT];
    end
  end

  // whoever pulls the line low, the processor restarts from it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset_n <= 1'b0;
    end else begin
      cpu_reset_n <= reset_line_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run, halt and wait

  // the edge latch keeps a falling edge that came while not waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_n_q <= 1'b1;
      nmi_pending_q <= 1'b0;
    end else begin
      nmi_n_q <= nmi_n;
      if (nmi_n_q && !nmi_n) begin
        nmi_pending_q <= 1'b1;
      end else if (cycle_en && state_q == board_bus_pkg::WAITING) begin
        nmi_pending_q <= 1'b0;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    if (!cpu_reset_n) begin
      state_d = board_bus_pkg::RUN;
    end else if (cycle_en) begin
      unique case (state_q)
        board_bus_pkg::RUN: begin
          // stops only where an instruction ends
          if (cpu_req.instr_end && !run_stop) begin
            state_d = board_bus_pkg::HALTED;
          end else if (cpu_req.instr_end && cpu_req.wait_exec) begin
            state_d = board_bus_pkg::WAITING;
          end
        end
        board_bus_pkg::HALTED: begin
          if (run_stop) begin
            state_d = board_bus_pkg::RUN;
          end
        end
        board_bus_pkg::WAITING: begin
          if (!irq_n || nmi_pending_q) begin
            state_d = board_bus_pkg::RUN;
          end
        end
        default: begin
          state_d = board_bus_pkg::RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= board_bus_pkg::RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_step <= 1'b0;
    end else begin
      cpu_step <= cycle_en && cpu_reset_n && state_d == board_bus_pkg::RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backplane buffers

  assign bus_active = cpu_reset_n && state_d == board_bus_pkg::RUN;
  assign data_drive = bus_active && cpu_req.addr_valid && !cpu_req.rw;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_released <= 1'b0;
      address_out <= '0;
      address_oe <= 1'b0;
      read_write <= 1'b1;
      memory_address_valid <= 1'b0;
    end else begin
      bus_released <= !bus_active;
      address_out <= cpu_req.addr;
      address_oe <= bus_active;
      read_write <= bus_active ? cpu_req.rw : 1'b1;
      memory_address_valid <= bus_active && cpu_req.addr_valid;
    end
  end

  // with a debug module fitted the qualifier pin is only listened to
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_address_valid_qualifier_out <= 1'b0;
      user_address_valid_qualifier_oe <= 1'b1;
    end else begin
      user_address_valid_qualifier_out <= bus_active && cpu_req.addr_valid;
      user_address_valid_qualifier_oe <= !board_cfg_q[`CFG_DEBUG_BIT];
    end
  end

  // backplane data is negative true in both directions
  bidir_line_cell #(
    .WIDTH(`DATA_W),
    .INVERT(1'b1)
  ) u_data_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .drive_d(cpu_req.wdata),
    .enable_d({`DATA_W{data_drive}}),
    .pin_in(data_n_in),
    .pin_out(data_n_out),
    .pin_oe(data_n_oe),
    .sample_q(cpu_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // first parallel adapter, port A

  bidir_line_cell #(
    .WIDTH(`DATA_W),
    .INVERT(1'b0)
  ) u_port_a_cell (
    .aclk(aclk),
    .aresetn(aresetn),
    .drive_d(port_a_out_q),
    .enable_d(direction_q),
    .pin_in(first_adapter_port_a_line_in),
    .pin_out(first_adapter_port_a_line_out),
    .pin_oe(first_adapter_port_a_line_oe),
    .sample_q(port_a_sample)
  );

  // output lines read back the latch, input lines the pin
  assign port_a_view = adapter_ctrl_q[`CTRL_SELECT_BIT]
    ? ((port_a_out_q & direction_q) | (port_a_sample & ~direction_q))
    : direction_q;

  assign status_view = {
    2'h0,
    user_address_valid_qualifier_in,
    reset_line_in,
    refresh_grant,
    state_q == board_bus_pkg::WAITING,
    state_q == board_bus_pkg::HALTED,
    bus_released
  };

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  // the held address and data are written only once the pending response is taken
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[`DATA_W-1:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (awaddr_q)
        `REG_PORT_A, `REG_ADAPTER_CTRL, `REG_BOARD_CFG, `REG_STATUS: begin
          s_axi_bresp <= `RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= `RESP_DECERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers; status ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adapter_ctrl_q <= `ADAPTER_CTRL_RESET;
      direction_q <= `DIRECTION_RESET;
      port_a_out_q <= `PORT_A_OUT_RESET;
      board_cfg_q <= `BOARD_CFG_RESET;
    end else if (do_write && wstrb0_q) begin
      unique case (awaddr_q)
        `REG_PORT_A: begin
          if (adapter_ctrl_q[`CTRL_SELECT_BIT]) begin
            port_a_out_q <= wdata_q;
          end else begin
            direction_q <= wdata_q;
          end
        end
        `REG_ADAPTER_CTRL: begin
          adapter_ctrl_q <= wdata_q;
        end
        `REG_BOARD_CFG: begin
          board_cfg_q <= wdata_q;
        end
        default: begin
          board_cfg_q <= board_cfg_q;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_PORT_A: begin
          s_axi_rdata <= {24'h000000, port_a_view};
        end
        `REG_ADAPTER_CTRL: begin
          s_axi_rdata <= {24'h000000, adapter_ctrl_q};
        end
        `REG_BOARD_CFG: begin
          s_axi_rdata <= {24'h000000, board_cfg_q};
        end
        `REG_STATUS: begin
          s_axi_rdata <= {24'h000000, status_view};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // board_system_bus_interface
`default_nettype wire

// *** core/board_bus_defines.svh ***
// Summary of operation
// - bus released indication low when running
// - released high when halted or waiting
// - released: drivers off, outputs inactive
// - either interrupt request ends the wait
// - run/stop level: high runs, low stops
// - halt at instruction end, address-valid low
// - reset line driven out, external low restarts
// - read/write high reads, low writes
// - read/write at read level idle, halted
// - no debug module: qualifier copies address-valid
// - low refresh request starts refresh cycle
// - refresh stops both phases, memory clock runs
// - refresh grant high commands memory refresh
// - data bits bidirectional only while enabled
// - address bits driven through enabled buffers
// - direction bit 0 input, 1 output
// - port line n follows direction bit n
// - address-valid marks valid address on bus
// - memory clock is ungated phase-two copy
// - control bit 2 selects data or direction
`ifndef BOARD_BUS_DEFINES_SVH
`define BOARD_BUS_DEFINES_SVH

`define ADDR_W 16
`define DATA_W 8
`define AXI_ADDR_W 8

`define REG_PORT_A 8'h00
`define REG_ADAPTER_CTRL 8'h04
`define REG_BOARD_CFG 8'h08
`define REG_STATUS 8'h0C

`define CTRL_SELECT_BIT 2
`define CFG_DEBUG_BIT 0
`define CFG_SOFT_RESET_BIT 1
`define ST_RELEASED_BIT 0
`define ST_HALTED_BIT 1
`define ST_WAITING_BIT 2
`define ST_GRANT_BIT 3
`define ST_RESET_LINE_BIT 4
`define ST_QUALIFIER_BIT 5

`define ADAPTER_CTRL_RESET 8'h00
`define DIRECTION_RESET 8'h00
`define PORT_A_OUT_RESET 8'h00
`define BOARD_CFG_RESET 8'h00

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`define CLK_PERIOD_PS 8000
`define PHASE_PERIOD_NS 1000
`define PHASE_HALF_CYCLES ((`PHASE_PERIOD_NS * 1000 / `CLK_PERIOD_PS) / 2)
`define PHASE_CNT_W 7
`define RESET_PULSE_NS 20000
`define RESET_CYCLES ((`RESET_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_CNT_W 12

`endif

// *** core/board_bus_pkg.sv ***
package board_bus_pkg;

  typedef enum logic [1:0] {
    RUN,
    HALTED,
    WAITING
  } run_state_e;

  // what the processor core presents in a machine cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rw;
    logic addr_valid;
    logic instr_end;
    logic wait_exec;
  } cpu_req_s;

endpackage

// *** core/bidir_line_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
module bidir_line_cell #(
  parameter int WIDTH = 8,
  parameter bit INVERT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] drive_d,
  input wire logic [WIDTH-1:0] enable_d,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] sample_q
);

  // per bit: the line drives only where its enable is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= INVERT ? ~drive_d : drive_d;
      pin_oe <= enable_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= '0;
    end else begin
      sample_q <= INVERT ? ~pin_in : pin_in;
    end
  end

endmodule // bidir_line_cell
`default_nettype wire

// *** verification/board_bus_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module board_bus_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire board_bus_pkg::cpu_req_s cpu_req,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic cpu_reset_n,
  input wire logic run_stop,
  input wire logic bus_released,
  input wire logic address_oe,
  input wire logic [7:0] data_n_out,
  input wire logic [7:0] data_n_oe,
  input wire logic read_write,
  input wire logic memory_address_valid,
  input wire logic user_address_valid_qualifier_out,
  input wire logic user_address_valid_qualifier_oe,
  input wire logic reset_line_in,
  input wire logic refresh_request_n,
  input wire logic refresh_grant,
  input wire logic phase_one_clock,
  input wire logic phase_two_clock,
  input wire logic ungated_memory_clock
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence refresh_held;
    refresh_grant ##1 refresh_grant;
  endsequence
  rel_drivers_a: assert property (bus_released |-> !address_oe && data_n_oe == 8'h00)
    else $error("bus driven while released");
  rel_valid_a: assert property (bus_released |-> !memory_address_valid)
    else $error("address valid while released");
  rel_rw_a: assert property (bus_released |-> read_write)
    else $error("write level while released");
  data_dir_a: assert property (|data_n_oe |-> !read_write && memory_address_valid)
    else $error("data driven outside a write");
  data_inv_a: assert property (|data_n_oe |-> data_n_out == ~$past(cpu_req.wdata))
    else $error("data not inverted");
  grant_follow_a: assert property ($past(aresetn) |-> refresh_grant == !$past(refresh_request_n))
    else $error("grant does not follow request");
  phase_stop_a: assert property (refresh_held |-> !phase_one_clock && !phase_two_clock)
    else $error("phase clock during refresh");
  mem_clock_a: assert property (1'b1 |-> ##[1:70] $changed(ungated_memory_clock))
    else $error("memory clock stalled");
  qual_copy_a: assert property (user_address_valid_qualifier_oe |->
    user_address_valid_qualifier_out == memory_address_valid)
    else $error("qualifier differs from address valid");
  reset_in_a: assert property (!reset_line_in |=> !cpu_reset_n)
    else $error("external reset ignored");
  halt_hold_a: assert property (bus_released && !run_stop && irq_n && nmi_n && reset_line_in
    && cpu_reset_n && $past(cpu_reset_n) |=> bus_released)
    else $error("release dropped without cause");
endmodule // board_bus_chk

bind board_system_bus_interface board_bus_chk chk_u (.aclk, .aresetn, .cpu_req, .irq_n, .nmi_n,
  .cpu_reset_n, .run_stop, .bus_released, .address_oe, .data_n_out, .data_n_oe, .read_write,
  .memory_address_valid, .user_address_valid_qualifier_out, .user_address_valid_qualifier_oe,
  .reset_line_in, .refresh_request_n, .refresh_grant, .phase_one_clock, .phase_two_clock,
  .ungated_memory_clock);
`default_nettype wire

// *** verification/backplane_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module backplane_model (
  input wire logic aclk,
  input wire logic reset_switch,
  input wire logic reset_line_oe,
  output logic reset_line_in,
  input wire logic [7:0] mem_word,
  input wire logic read_cycle,
  input wire logic [7:0] data_n_out,
  input wire logic [7:0] data_n_oe,
  output logic [7:0] data_n_in,
  input wire logic debug_fitted,
  input wire logic debug_qual,
  input wire logic qual_out,
  input wire logic qual_oe,
  output logic qual_in,
  input wire logic [7:0] pa_ext,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  output logic [7:0] pa_in
);
  logic [7:0] float_q = 8'h55;
  // undriven lines wander so a stale value never looks valid
  always @(posedge aclk) float_q <= ~float_q;
  // pull-up: low only while the board or the switch pulls it
  assign reset_line_in = !(reset_line_oe || reset_switch);
  assign data_n_in = (data_n_oe & data_n_out) |
    (~data_n_oe & (read_cycle ? ~mem_word : float_q));
  assign qual_in = debug_fitted ? debug_qual : (qual_oe ? qual_out : float_q[0]);
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
endmodule // backplane_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  board_bus_pkg::cpu_req_s cpu_req = '{16'h1234, 8'h5A, 1'b0, 1'b1, 1'b0, 1'b0};
  logic irq_n = 1'b1, nmi_n = 1'b1, run_stop = 1'b1, refresh_request_n = 1'b1;
  logic cpu_step, cpu_reset_n, bus_released, address_oe, read_write, memory_address_valid;
  logic [7:0] cpu_rdata, data_n_in, data_n_out, data_n_oe;
  logic [15:0] address_out;
  logic user_address_valid_qualifier_in, user_address_valid_qualifier_out;
  logic user_address_valid_qualifier_oe, reset_line_in, reset_line_out, reset_line_oe;
  logic refresh_grant, phase_one_clock, phase_two_clock, ungated_memory_clock, m;
  logic [7:0] first_adapter_port_a_line_in, first_adapter_port_a_line_out;
  logic [7:0] first_adapter_port_a_line_oe;
  logic reset_switch = 1'b0, debug_fitted = 1'b0;
  logic [31:0] rd;
  int mismatches = 0, check_count = 0, cyc = 0, n, tog;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [1:0] r;} row_s;
  row_s rows [8] = '{'{1'b1, 8'h04, 8'h00, 2'h0}, '{1'b1, 8'h00, 8'hA5, 2'h0},
    '{1'b0, 8'h00, 8'hA5, 2'h0}, '{1'b1, 8'h04, 8'h04, 2'h0}, '{1'b1, 8'h00, 8'h3C, 2'h0},
    '{1'b0, 8'h04, 8'h04, 2'h0}, '{1'b1, 8'h10, 8'hFF, 2'h3}, '{1'b0, 8'h10, 8'h00, 2'h3}};

  board_system_bus_interface dut_u (.*);
  backplane_model model_u (.aclk(aclk), .reset_switch(reset_switch),
    .reset_line_oe(reset_line_oe), .reset_line_in(reset_line_in), .mem_word(8'hC3),
    .read_cycle(read_write & memory_address_valid), .data_n_out(data_n_out),
    .data_n_oe(data_n_oe), .data_n_in(data_n_in), .debug_fitted(debug_fitted),
    .debug_qual(1'b0), .qual_out(user_address_valid_qualifier_out),
    .qual_oe(user_address_valid_qualifier_oe), .qual_in(user_address_valid_qualifier_in),
    .pa_ext(8'h5A), .pa_out(first_adapter_port_a_line_out),
    .pa_oe(first_adapter_port_a_line_oe), .pa_in(first_adapter_port_a_line_in));

  always #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic step_wait;
    do @(posedge aclk); while (cpu_step !== 1'b1);
  endtask
  // either channel may be taken first, so each is dropped on its own ready
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!((s_axi_awready || !s_axi_awvalid) && (s_axi_wready || !s_axi_wvalid)));
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    aresetn <= 1'b1;
    tick(2);
    chk("reset_oe", reset_line_oe, 1);
    chk("reset_drive", reset_line_out, 0);
    chk("core_reset", cpu_reset_n, 0);
    chk("rw_idle", read_write, 1);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rsp);
      else axi_rd(rows[i].a, rd, rsp);
      if (!rows[i].wr) chk("rdata", rd, {24'h0, rows[i].d});
      chk("resp", rsp, rows[i].r);
    end
    tick(3);
    chk("pa_oe", first_adapter_port_a_line_oe, 8'hA5);
    chk("pa_out", first_adapter_port_a_line_out, 8'h3C);
    axi_rd(8'h00, rd, rsp);
    chk("pa_pins", rd, 32'h7E);
    while (cpu_reset_n !== 1'b1) tick(1);
    chk("reset_free", reset_line_oe, 0);
    step_wait();
    tick(2);
    chk("addr", address_out, 16'h1234);
    chk("addr_oe", address_oe, 1);
    chk("rw_write", read_write, 0);
    chk("data_out", data_n_out, 8'hA5);
    chk("data_oe", data_n_oe, 8'hFF);
    chk("addr_valid", memory_address_valid, 1);
    chk("released", bus_released, 0);
    chk("qual", user_address_valid_qualifier_out, 1);
    cpu_req.rw <= 1'b1;
    step_wait();
    step_wait();
    tick(2);
    chk("rw_read", read_write, 1);
    chk("rd_oe", data_n_oe, 8'h00);
    chk("rdata_in", cpu_rdata, 8'hC3);
    axi_wr(8'h08, 8'h01, rsp);
    debug_fitted <= 1'b1;
    tick(3);
    chk("qual_oe", user_address_valid_qualifier_oe, 0);
    // status bit 5 must follow the debug module's pin, not our own copy
    axi_rd(8'h0C, rd, rsp);
    chk("dbg_status", rd, 32'h10);
    axi_wr(8'h08, 8'h00, rsp);
    debug_fitted <= 1'b0;
    cpu_req.instr_end <= 1'b1;
    // run with writes so the halted read level is really forced
    cpu_req.rw <= 1'b0;
    @(posedge phase_one_clock);
    tick(1);
    run_stop <= 1'b0;
    while (bus_released !== 1'b1) tick(1);
    tick(1);
    chk("halt_oe", address_oe, 0);
    chk("halt_valid", memory_address_valid, 0);
    chk("halt_rw", read_write, 1);
    axi_rd(8'h0C, rd, rsp);
    chk("halt_status", rd, 32'h13);
    n = 0;
    repeat (300) begin
      tick(1);
      n += cpu_step;
    end
    chk("halt_steps", n, 0);
    run_stop <= 1'b1;
    while (bus_released !== 1'b0) tick(1);
    cpu_req.wait_exec <= 1'b1;
    while (bus_released !== 1'b1) tick(1);
    cpu_req.wait_exec <= 1'b0;
    irq_n <= 1'b0;
    while (bus_released !== 1'b0) tick(1);
    irq_n <= 1'b1;
    cpu_req.wait_exec <= 1'b1;
    while (bus_released !== 1'b1) tick(1);
    cpu_req.wait_exec <= 1'b0;
    tick(200);
    chk("wait_hold", bus_released, 1);
    nmi_n <= 1'b0;
    n = 0;
    while (bus_released !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    nmi_n <= 1'b1;
    chk("wait_nmi", n < 130, 1);
    refresh_request_n <= 1'b0;
    tick(3);
    chk("grant", refresh_grant, 1);
    chk("ph1", phase_one_clock, 0);
    chk("ph2", phase_two_clock, 0);
    m = ungated_memory_clock;
    n = 0;
    tog = 0;
    repeat (200) begin
      tick(1);
      tog += (ungated_memory_clock !== m);
      m = ungated_memory_clock;
      n += cpu_step;
    end
    chk("mem_clock", tog > 0, 1);
    chk("ref_steps", n, 0);
    refresh_request_n <= 1'b1;
    tick(3);
    chk("grant_off", refresh_grant, 0);
    n = 0;
    repeat (300) begin
      tick(1);
      n += cpu_step;
    end
    chk("resume", n > 0, 1);
    reset_switch <= 1'b1;
    tick(3);
    chk("switch_line", reset_line_in, 0);
    chk("switch_core", cpu_reset_n, 0);
    reset_switch <= 1'b0;
    tick(3);
    axi_wr(8'h08, 8'h02, rsp);
    tick(2);
    chk("soft_line", reset_line_oe, 1);
    chk("soft_core", cpu_reset_n, 0);
    close_out();
  end
endmodule // testbench
`default_nettype wire
